//--- rtl/crro_pkg.sv
// Purpose: Shared constants and types for the cache/TLB RAM readout block
// Assumes: 32-bit coprocessor data path, data cache of four ways
// Notes: Coprocessor selector codes and location word fields live here
package crro_pkg;
	// ----------------------------------------------------------------
	// Coprocessor selector codes
	// ----------------------------------------------------------------
	localparam logic [2:0] CRRO_OPC1 = 3'h3; // Primary opcode of all readout ops
	localparam logic [3:0] CRRO_CRN = 4'hf; // Main register number
	localparam logic [3:0] CRRO_CRM_RESULT = 4'h0; // Result registers
	localparam logic [3:0] CRRO_CRM_TAG = 4'h2; // Tag read triggers
	localparam logic [3:0] CRRO_CRM_DATA = 4'h4; // Data read triggers
	localparam logic [2:0] CRRO_OPC2_0 = 3'h0; // Result 0 / data cache / data cache
	localparam logic [2:0] CRRO_OPC2_1 = 3'h1; // Result 1 / instr cache
	localparam logic [2:0] CRRO_OPC2_2 = 3'h2; // Result 2 / TLB
	// ----------------------------------------------------------------
	// Location word fields and geometry
	// ----------------------------------------------------------------
	localparam int CRRO_DC_WAYS = 4; // Data cache associativity
	localparam int CRRO_WAY_HI = 31; // Way field top bit
	localparam int CRRO_WAY_LO = 30; // Way field bottom bit
	localparam int CRRO_SET_LO = 6; // Set index bottom bit
	localparam int CRRO_SET_OFS = 5; // Set index top bit is S plus this
	localparam int CRRO_DW_HI = 5; // Doubleword offset top bit
	localparam int CRRO_DW_LO = 3; // Doubleword offset bottom bit
	localparam int CRRO_DC_SIZE = 32768; // Default data cache size in bytes
	localparam int CRRO_TAG_UNIT = 8192; // Size at which all tag bits are valid
	localparam logic [31:0] CRRO_RESET_WORD = 32'h0000_0000; // Result reset value
	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid; // Access strobe, one cycle
		logic write; // 1 = write to trigger, 0 = read of result
		logic [2:0] opc1; // Primary opcode
		logic [3:0] crn; // Main register
		logic [3:0] crm; // Subregister
		logic [2:0] opc2; // Secondary opcode
		logic [31:0] wdata; // Location word
	} crro_req_t;
	typedef struct packed {
		logic [1:0] dirty_state; // Coherency part held in dirty RAM
		logic [2:0] outer_attr; // Outer memory attributes
		logic [1:0] tag_state; // Coherency part held in tag RAM
		logic nonsecure_line_flag; // Line non-secure flag
		logic [28:0] tag_addr; // Physical address bits 39..11
	} crro_tag_t;
	typedef enum logic [1:0] {
		CRRO_OP_DTAG,
		CRRO_OP_DDATA,
		CRRO_OP_OTHER
	} crro_op_t;
endpackage

//--- rtl/crro_dcache_ram.sv
// Purpose: Data cache tag and data arrays with a one-cycle read port
// Assumes: Fill port is driven by the owning cache controller
// Notes: Arrays are kept here so the readout sees real contents
`timescale 1ns/1ps
`default_nettype none
module crro_dcache_ram
	import crro_pkg::*;
#(
	parameter int SET_W = 3, // Set index width
	parameter int WAYS = CRRO_DC_WAYS // Number of ways
)
(
	input wire logic clk,
	input wire logic fill_tag_we,
	input wire logic fill_data_we,
	input wire logic [1:0] fill_way,
	input wire logic [SET_W-1:0] fill_set,
	input wire logic [2:0] fill_dw,
	input wire crro_tag_t fill_tag,
	input wire logic [63:0] fill_data,
	input wire logic [1:0] rd_way,
	input wire logic [SET_W-1:0] rd_set,
	input wire logic [2:0] rd_dw,
	output crro_tag_t rd_tag,
	output logic [63:0] rd_data
);
	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	crro_tag_t tag_mem [WAYS*(2**SET_W)]; // One tag per line
	logic [63:0] data_mem [WAYS*(2**SET_W)*8]; // Eight doublewords per line

	// Linear line index; used for both ports
	function automatic int line_idx(input logic [1:0] w, input logic [SET_W-1:0] s);
		line_idx = int'(w) * (2**SET_W) + int'(s);
	endfunction

	// Write from the cache controller, registered read for readout
	always_ff @(posedge clk)
	begin
		if (fill_tag_we)
		begin
			tag_mem[line_idx(fill_way, fill_set)] <= fill_tag;
		end
		if (fill_data_we)
		begin
			data_mem[line_idx(fill_way, fill_set) * 8 + int'(fill_dw)] <= fill_data;
		end
		rd_tag <= tag_mem[line_idx(rd_way, rd_set)];
		rd_data <= data_mem[line_idx(rd_way, rd_set) * 8 + int'(rd_dw)];
	end
endmodule
`default_nettype wire

//--- rtl/crro_readout.sv
// Purpose: Debug readout of the raw data cache tag and data RAMs
// Assumes: Coprocessor accesses arrive as one-cycle strobes on req
// Notes: Instruction cache and TLB triggers are accepted but return zero
`timescale 1ns/1ps
`default_nettype none
module crro_readout
	import crro_pkg::*;
#(
	parameter int DC_SIZE = CRRO_DC_SIZE // Data cache size in bytes
)
(
	input wire logic clk,
	input wire logic reset,
	input wire crro_req_t req,
	input wire logic secure,
	input wire logic privileged,
	input wire logic fill_tag_we,
	input wire logic fill_data_we,
	input wire logic [1:0] fill_way,
	input wire logic [$clog2(DC_SIZE/CRRO_DC_WAYS)+CRRO_SET_OFS-CRRO_SET_LO:0] fill_set,
	input wire logic [2:0] fill_dw,
	input wire crro_tag_t fill_tag,
	input wire logic [63:0] fill_data,
	output logic ack,
	output logic undef,
	output logic [31:0] rdata
);
	// ----------------------------------------------------------------
	// Geometry
	// ----------------------------------------------------------------
	// S is log2(size/4); the set field spans S+5 down to 6
	localparam int S = $clog2(DC_SIZE / CRRO_DC_WAYS);
	localparam int SET_W = S + CRRO_SET_OFS - CRRO_SET_LO + 1;
	// Low tag bits that carry no meaning on larger caches
	localparam int TAG_BAD = $clog2(DC_SIZE / CRRO_TAG_UNIT);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	// Matches one selector of the readout space
	function automatic logic sel(input crro_req_t r, input logic [3:0] m, input logic [2:0] o);
		sel = r.opc1 == CRRO_OPC1 && r.crn == CRRO_CRN && r.crm == m && r.opc2 == o;
	endfunction

	logic allowed; // Secure and privileged
	logic hit_trig; // Any trigger register
	logic hit_res; // Any result register
	logic [1:0] way_w; // Way field of location word
	logic [SET_W-1:0] set_w; // Set field of location word
	logic [2:0] dw_w; // Doubleword field
	always_comb
	begin
		allowed = secure && privileged;
		hit_trig = req.write && (sel(req, CRRO_CRM_TAG, CRRO_OPC2_0)
			|| sel(req, CRRO_CRM_TAG, CRRO_OPC2_1) || sel(req, CRRO_CRM_DATA, CRRO_OPC2_0)
			|| sel(req, CRRO_CRM_DATA, CRRO_OPC2_1)
			|| sel(req, CRRO_CRM_DATA, CRRO_OPC2_2));
		hit_res = !req.write && (sel(req, CRRO_CRM_RESULT, CRRO_OPC2_0)
			|| sel(req, CRRO_CRM_RESULT, CRRO_OPC2_1)
			|| sel(req, CRRO_CRM_RESULT, CRRO_OPC2_2));
		// Bits 29 down to S+6 and 2:0 are never looked at
		way_w = req.wdata[CRRO_WAY_HI:CRRO_WAY_LO];
		set_w = req.wdata[S+CRRO_SET_OFS:CRRO_SET_LO];
		dw_w = req.wdata[CRRO_DW_HI:CRRO_DW_LO];
	end

	// ----------------------------------------------------------------
	// RAM arrays
	// ----------------------------------------------------------------
	logic [1:0] way_r, way_nxt; // Latched way for the RAM read
	logic [SET_W-1:0] set_r, set_nxt; // Latched set
	logic [2:0] dw_r, dw_nxt; // Latched doubleword
	crro_tag_t ram_tag; // Tag of the selected line
	logic [63:0] ram_data; // Selected doubleword
	crro_dcache_ram #(.SET_W(SET_W), .WAYS(CRRO_DC_WAYS)) u_ram
	(
		.clk(clk),
		.fill_tag_we(fill_tag_we),
		.fill_data_we(fill_data_we),
		.fill_way(fill_way),
		.fill_set(fill_set),
		.fill_dw(fill_dw),
		.fill_tag(fill_tag),
		.fill_data(fill_data),
		.rd_way(way_nxt),
		.rd_set(set_nxt),
		.rd_dw(dw_nxt),
		.rd_tag(ram_tag),
		.rd_data(ram_data)
	);

	// ----------------------------------------------------------------
	// Operation tracking and result registers
	// ----------------------------------------------------------------
	logic pend_r, pend_nxt; // RAM answer arrives next cycle
	crro_op_t op_r, op_nxt; // Operation in flight
	logic [31:0] res0_r, res0_nxt; // Result register 0
	logic [31:0] res1_r, res1_nxt; // Result register 1
	logic [31:0] res2_r, res2_nxt; // Result register 2
	logic ack_nxt, undef_nxt; // Answer strobes
	logic [31:0] rdata_nxt; // Read answer
	logic [28:0] tag_clean; // Tag with invalid low bits cleared

	always_comb
	begin
		pend_nxt = 1'b0;
		op_nxt = op_r;
		way_nxt = way_r;
		set_nxt = set_r;
		dw_nxt = dw_r;
		res0_nxt = res0_r;
		res1_nxt = res1_r;
		res2_nxt = res2_r;
		ack_nxt = 1'b0;
		undef_nxt = 1'b0;
		rdata_nxt = 32'h0000_0000;
		tag_clean = ram_tag.tag_addr & ~((29'h1 << TAG_BAD) - 29'h1);
		// Capture the RAM answer into the results
		if (pend_r)
		begin
			unique case (op_r)
				CRRO_OP_DTAG:
				begin
					res0_nxt = {27'h0, ram_tag.outer_attr, ram_tag.dirty_state};
					res1_nxt = {ram_tag.tag_state, ram_tag.nonsecure_line_flag, tag_clean};
					res2_nxt = 32'h0000_0000;
				end
				CRRO_OP_DDATA:
				begin
					res0_nxt = ram_data[31:0];
					res1_nxt = ram_data[63:32];
					res2_nxt = 32'h0000_0000;
				end
				CRRO_OP_OTHER:
				begin
					// Instruction cache and TLB arrays are not held here
					res0_nxt = 32'h0000_0000;
					res1_nxt = 32'h0000_0000;
					res2_nxt = 32'h0000_0000;
				end
			endcase
		end
		// New request; the ack for a trigger waits for the results so a
		// following read can never see stale contents
		if (req.valid && !pend_r)
		begin
			if (!allowed && (hit_trig || hit_res))
			begin
				undef_nxt = 1'b1;
			end
			else if (hit_trig)
			begin
				pend_nxt = 1'b1;
				way_nxt = way_w;
				set_nxt = set_w;
				dw_nxt = dw_w;
				if (sel(req, CRRO_CRM_TAG, CRRO_OPC2_0))
				begin
					op_nxt = CRRO_OP_DTAG;
				end
				else if (sel(req, CRRO_CRM_DATA, CRRO_OPC2_0))
				begin
					op_nxt = CRRO_OP_DDATA;
				end
				else
				begin
					op_nxt = CRRO_OP_OTHER;
				end
			end
			else if (hit_res)
			begin
				ack_nxt = 1'b1;
				unique case (req.opc2)
					CRRO_OPC2_0: rdata_nxt = res0_r;
					CRRO_OPC2_1: rdata_nxt = res1_r;
					default: rdata_nxt = res2_r;
				endcase
			end
			else
			begin
				// Outside the readout space: acknowledged, reads zero
				ack_nxt = 1'b1;
			end
		end
		if (pend_r)
		begin
			ack_nxt = 1'b1; // Trigger completes with results in place
		end
	end

	// Register stage
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			pend_r <= 1'b0;
			op_r <= CRRO_OP_OTHER;
			way_r <= 2'h0;
			set_r <= '0;
			dw_r <= 3'h0;
			res0_r <= CRRO_RESET_WORD;
			res1_r <= CRRO_RESET_WORD;
			res2_r <= CRRO_RESET_WORD;
			ack <= 1'b0;
			undef <= 1'b0;
			rdata <= 32'h0000_0000;
		end
		else
		begin
			pend_r <= pend_nxt;
			op_r <= op_nxt;
			way_r <= way_nxt;
			set_r <= set_nxt;
			dw_r <= dw_nxt;
			res0_r <= res0_nxt;
			res1_r <= res1_nxt;
			res2_r <= res2_nxt;
			ack <= ack_nxt;
			undef <= undef_nxt;
			rdata <= rdata_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_undef_nonsecure: assert property (@(posedge clk) disable iff (reset)
		req.valid && !pend_r && !(secure && privileged) && (hit_trig || hit_res)
		|=> undef && !ack) else $error("denied access not flagged undefined");
	a_no_ack_denied: assert property (@(posedge clk) disable iff (reset)
		undef |-> !ack && rdata == 32'h0) else $error("undefined access also answered");
	a_trig_ack_two: assert property (@(posedge clk) disable iff (reset)
		req.valid && !pend_r && allowed && hit_trig |=> !ack ##1 ack)
		else $error("trigger ack timing wrong");
	a_res0_read: assert property (@(posedge clk) disable iff (reset)
		req.valid && !pend_r && allowed && hit_res && req.opc2 == CRRO_OPC2_0
		|=> ack && rdata == $past(res0_r)) else $error("result 0 read wrong");
	a_tag_upper_zero: assert property (@(posedge clk) disable iff (reset)
		$past(pend_r) && $past(op_r) == CRRO_OP_DTAG |-> res0_r[31:5] == 27'h0)
		else $error("tag result 0 upper bits not zero");
	a_tag_flag_bit: assert property (@(posedge clk) disable iff (reset)
		pend_r && op_r == CRRO_OP_DTAG |=> res1_r[29] == $past(ram_tag.nonsecure_line_flag))
		else $error("line flag misplaced");
	a_data_split: assert property (@(posedge clk) disable iff (reset)
		pend_r && op_r == CRRO_OP_DDATA |=> {res1_r, res0_r} == $past(ram_data))
		else $error("doubleword split wrong");
	a_way_capture: assert property (@(posedge clk) disable iff (reset)
		req.valid && !pend_r && allowed && hit_trig
		|=> way_r == $past(req.wdata[31:30]) && dw_r == $past(req.wdata[5:3]))
		else $error("location fields not captured");
	a_res2_zero: assert property (@(posedge clk) disable iff (reset)
		##1 $past(pend_r) |-> res2_r == 32'h0) else $error("result 2 not zero");
endmodule
`default_nettype wire

//--- tb/cache_tlb_ram_debug_readout_test.sv
// Purpose: Self-checking bench for the cache RAM readout block
// Assumes: 32KB data cache, so the two low tag bits read as zero
// Notes: The driver queues expected answers, a monitor pops and checks them
`timescale 1ns/1ps
`default_nettype none
module cache_tlb_ram_debug_readout_test
	import crro_pkg::*;
;
	// ----
	// Signals and bench state
	// ----
	localparam int DC_SIZE = 32768; // Four ways of 8KB
	localparam int SET_W = $clog2(DC_SIZE/CRRO_DC_WAYS); // Set bits, S+5 down to 6
	localparam int NLOW = $clog2(DC_SIZE/CRRO_TAG_UNIT); // Invalid tag bits
	typedef struct {logic undef_exp; logic chk; logic [31:0] val;} crro_exp_t;
	logic clk = 1'b0;
	logic reset = 1'b1;
	crro_req_t req = '0;
	logic secure = 1'b1;
	logic privileged = 1'b1;
	logic fill_tag_we = 1'b0;
	logic fill_data_we = 1'b0;
	logic [1:0] fill_way = 2'h0;
	logic [SET_W-1:0] fill_set = '0;
	logic [2:0] fill_dw = 3'h0;
	crro_tag_t fill_tag = '0;
	logic [63:0] fill_data = 64'h0;
	logic ack;
	logic undef;
	logic [31:0] rdata;
	crro_exp_t exp_q[$]; // Oldest expected answer first
	crro_exp_t mon_e; // Entry taken by the monitor
	int fail_count = 0;
	int tests_run = 0;
	logic [15:0] lfsr_r = 16'hd4c8; // Seed 54472
	logic [63:0] ent_data[4]; // One entry per way
	crro_tag_t ent_tag[4];
	logic [SET_W-1:0] ent_set[4];
	logic [2:0] ent_dw[4];
	logic [31:0] w;
	logic [31:0] w2;

	crro_readout #(.DC_SIZE(DC_SIZE)) dut_u (.clk(clk), .reset(reset), .req(req),
		.secure(secure), .privileged(privileged), .fill_tag_we(fill_tag_we),
		.fill_data_we(fill_data_we), .fill_way(fill_way), .fill_set(fill_set),
		.fill_dw(fill_dw), .fill_tag(fill_tag), .fill_data(fill_data), .ack(ack),
		.undef(undef), .rdata(rdata));

	// Free-running 100 MHz clock
	always #5 clk = ~clk;

	// ----
	// Helpers
	// ----
	function automatic logic [15:0] lfsr_step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	// Two steps give one fresh 32-bit word
	task automatic rnd(output logic [31:0] v);
		lfsr_r = lfsr_step(lfsr_r);
		v[31:16] = lfsr_r;
		lfsr_r = lfsr_step(lfsr_r);
		v[15:0] = lfsr_r;
	endtask

	// Location word with junk in the ignored fields
	function automatic logic [31:0] loc(input int i, input logic [31:0] junk);
		return {i[1:0], junk[10:0], ent_set[i], ent_dw[i], junk[13:11]};
	endfunction

	task automatic cmp_data(input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			fail_count++;
			$display("wrong value at %0t: expected %h got %h", $time, exp, got);
		end
	endtask

	task automatic cmp_flag(input logic exp, input logic got);
		cmp_data({31'h0, exp}, {31'h0, got});
	endtask

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Monitor: every answer pulse must match the oldest queued note
	always @(negedge clk)
	begin
		if (ack === 1'b1 || undef === 1'b1)
		begin
			if (exp_q.size() == 0)
				cmp_flag(1'b0, 1'b1);
			else
			begin
				mon_e = exp_q.pop_front();
				cmp_flag(mon_e.undef_exp, undef);
				cmp_flag(!mon_e.undef_exp, ack);
				if (mon_e.chk)
					cmp_data(mon_e.val, rdata);
			end
		end
	end

	// One access; waits for its answer so requests never overlap
	task automatic acc(input logic wr, input logic [3:0] crm, input logic [2:0] opc2,
		input logic [31:0] wd, input logic deny, input logic chk, input logic [31:0] ev);
		int n;
		exp_q.push_back('{deny, chk, ev});
		@(posedge clk);
		req <= '{1'b1, wr, CRRO_OPC1, CRRO_CRN, crm, opc2, wd};
		@(posedge clk);
		req.valid <= 1'b0;
		for (n = 0; n < 4; n++)
		begin
			@(negedge clk);
			if (ack === 1'b1 || undef === 1'b1)
				break;
		end
		// A missing answer ends the run as a failure
		if (n == 4)
		begin
			fail_count++;
			wrap_up();
		end
	endtask

	task automatic rd(input logic [2:0] n, input logic [31:0] ev);
		acc(1'b0, CRRO_CRM_RESULT, n, 32'h0, 1'b0, 1'b1, ev);
	endtask

	task automatic trig(input logic [3:0] crm, input logic [2:0] opc2, input logic [31:0] wd);
		acc(1'b1, crm, opc2, wd, 1'b0, 1'b0, 32'h0);
	endtask

	// Writes one tag and one doubleword through the fill port
	task automatic fill(input int i);
		@(posedge clk);
		fill_tag_we <= 1'b1;
		fill_data_we <= 1'b1;
		fill_way <= i[1:0];
		fill_set <= ent_set[i];
		fill_dw <= ent_dw[i];
		fill_tag <= ent_tag[i];
		fill_data <= ent_data[i];
		@(posedge clk);
		fill_tag_we <= 1'b0;
		fill_data_we <= 1'b0;
	endtask

	// ----
	// Main sequence
	// ----
	initial
	begin
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		for (int k = 0; k < 3; k++)
			rd(k[2:0], 32'h0);
		$display("test reset done");
		// Random entries, one per way, read back right after each trigger
		for (int i = 0; i < 4; i++)
		begin
			rnd(w);
			rnd(w2);
			ent_data[i] = {w, w2};
			rnd(w);
			rnd(w2);
			ent_tag[i] = {w, w2[4:0]};
			ent_set[i] = w2[SET_W+7:8];
			ent_dw[i] = w2[31:29];
			fill(i);
		end
		for (int i = 0; i < 4; i++)
		begin
			rnd(w);
			trig(CRRO_CRM_DATA, CRRO_OPC2_0, loc(i, w));
			rd(3'h0, ent_data[i][31:0]);
			rd(3'h1, ent_data[i][63:32]);
			rd(3'h2, 32'h0);
			trig(CRRO_CRM_TAG, CRRO_OPC2_0, loc(i, ~w));
			rd(3'h0, {27'h0, ent_tag[i].outer_attr, ent_tag[i].dirty_state});
			rd(3'h1, {ent_tag[i].tag_state, ent_tag[i].nonsecure_line_flag,
				(ent_tag[i].tag_addr >> NLOW) << NLOW});
		end
		$display("test readout done");
		// Non-secure or unprivileged: refused, results left as they were
		trig(CRRO_CRM_DATA, CRRO_OPC2_0, loc(0, 32'h0));
		for (int c = 0; c < 3; c++)
		begin
			@(posedge clk);
			{secure, privileged} <= c[1:0];
			acc(1'b1, CRRO_CRM_DATA, CRRO_OPC2_0, loc(1, 32'h0), 1'b1, 1'b0, 32'h0);
			acc(1'b0, CRRO_CRM_RESULT, CRRO_OPC2_0, 32'h0, 1'b1, 1'b0, 32'h0);
		end
		@(posedge clk);
		{secure, privileged} <= 2'h3;
		rd(3'h0, ent_data[0][31:0]);
		$display("test denied done");
		// Instruction cache and TLB triggers clear all results
		for (int t = 0; t < 3; t++)
		begin
			trig(CRRO_CRM_DATA, CRRO_OPC2_0, loc(2, 32'h0));
			trig(t == 0 ? CRRO_CRM_TAG : CRRO_CRM_DATA, t == 2 ? CRRO_OPC2_2 : CRRO_OPC2_1,
				loc(3, 32'h0));
			for (int k = 0; k < 3; k++)
				rd(k[2:0], 32'h0);
		end
		$display("test other triggers done");
		// Unmapped selectors answer with zero
		acc(1'b0, 4'h1, CRRO_OPC2_0, 32'h0, 1'b0, 1'b1, 32'h0);
		rd(3'h5, 32'h0);
		acc(1'b1, 4'h6, CRRO_OPC2_0, 32'h0, 1'b0, 1'b0, 32'h0);
		$display("test unmapped done");
		repeat (3) @(posedge clk);
		cmp_data(32'h0, exp_q.size());
		wrap_up();
	end
endmodule
`default_nettype wire
